// >>> inc/i2c_cfg_consts.svh
// Offsets, reset values, field positions and timing counts for the
// bus configuration and data block.
// Assumes a 40 MHz clock and an 8-bit register port.
`ifndef I2C_CFG_CONSTS_SVH
`define I2C_CFG_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFF_CTL        8'h18
`define OFF_RATE       8'h1b
`define OFF_LOW        8'h1c
`define OFF_HIGH       8'h1d
`define OFF_BYTE       8'h1e
`define OFF_STAT       8'h1f

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_CTL        8'h00
`define RST_RATE       8'h00
`define RST_BYTE       8'h00
`define RST_LOW        8'h00
`define RST_HIGH       8'h40
`define RST_ZERO       8'h00

// ----------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------
`define CTL_ON_BIT     5
`define CTL_TEN_BIT    7
`define RATE_SEL_BIT   7
`define HIGH_KEEP_MASK 8'hc6
`define HIGH_ADDR_MASK 8'h06
`define HIGH_BAND_MASK 8'hc0
`define IGNORED_ID     8'h01
`define TEN_HDR        5'h1e
`define STAT_FULL      0
`define STAT_READY     1
`define STAT_HIT       2
`define STAT_RW        3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ        40
`define HOLD_NS_SLOW   300
`define HOLD_NS_MID    250
`define HOLD_CYC(ns)   (((ns) * `CLK_MHZ + 999) / 1000)
`define SM_SHIFT       2
`define FM_SHIFT       1

`endif

// >>> inc/i2c_cfg_pkg.sv
// Types shared by the bus configuration and data block.
// Assumes the constants header is compiled alongside.
package i2c_cfg_pkg;

  // ----------------------------------------------------------------
  // Register port request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // ----------------------------------------------------------------
  // Events from the serial engine, same clock
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       transmitting;
    logic       rx_valid;
    logic [7:0] rx_data;
    logic       addr_first;
    logic       addr_second;
    logic [7:0] addr_byte;
    logic       stop;
  } bus_evt_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_WAIT = 2'b01,
    RX_FULL = 2'b10
  } rx_state_t;

endpackage : i2c_cfg_pkg

// >>> verilog/scl_rate_gen.sv
// SCL half-period enable and data hold enable generator.
// Assumes a 40 MHz clock and a synchronous active-low reset copy.
`timescale 1ns/100ps
`include "i2c_cfg_consts.svh"
module scl_rate_gen
  import i2c_cfg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic       fast,
  input  wire logic [6:0] divider,
  input  wire logic [1:0] band,
  output logic            scl_tick,
  output logic            hold_tick
);

  logic [9:0] half_cnt;
  logic [3:0] hold_cnt;

  function automatic logic [9:0] half_len(input logic f, input logic [6:0] d);
    logic [9:0] base;
    base = {3'h0, d} + 10'h001;
    half_len = f ? (base << `FM_SHIFT) : (base << `SM_SHIFT);
  endfunction : half_len

  // Only bands 00 and 01 are defined; reserved codes take the 01 delay
  function automatic logic [3:0] hold_len(input logic [1:0] b);
    hold_len = (b == 2'b00) ? 4'(`HOLD_CYC(`HOLD_NS_SLOW))
                            : 4'(`HOLD_CYC(`HOLD_NS_MID));
  endfunction : hold_len

  // ----------------------------------------------------------------
  // Half period counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      half_cnt <= 10'h000;
      scl_tick <= 1'b0;
    end else if (!run) begin
      half_cnt <= 10'h000;
      scl_tick <= 1'b0;
    end else if (half_cnt <= 10'h001) begin
      half_cnt <= half_len(fast, divider);
      scl_tick <= 1'b1;
    end else begin
      half_cnt <= half_cnt - 10'h001;
      scl_tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Hold delay after each edge
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt  <= 4'h0;
      hold_tick <= 1'b0;
    end else if (!run) begin
      hold_cnt  <= 4'h0;
      hold_tick <= 1'b0;
    end else if (scl_tick) begin
      // Loaded one short: the registered tick supplies the last cycle
      hold_cnt  <= hold_len(band) - 4'h1;
      hold_tick <= 1'b0;
    end else begin
      hold_cnt  <= (hold_cnt != 4'h0) ? hold_cnt - 4'h1 : 4'h0;
      hold_tick <= (hold_cnt == 4'h1);
    end
  end

endmodule : scl_rate_gen

// >>> verilog/own_addr_match.sv
// Own slave address comparison for 7-bit and 10-bit addressing.
// Assumes address bytes arrive as one-cycle strobes on the same clock.
`timescale 1ns/100ps
`include "i2c_cfg_consts.svh"
module own_addr_match
  import i2c_cfg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clear,
  input  wire logic       ten_bit,
  input  wire logic [7:0] own_low,
  input  wire logic [1:0] own_top,
  input  wire logic       first,
  input  wire logic       second,
  input  wire logic [7:0] addr_byte,
  output logic            hit,
  output logic            hit_pulse,
  output logic            rw
);

  logic hdr_ok;
  logic match7;

  // Direction slot is not compared, and value 01h never answers in seven-bit mode
  assign match7 = (own_low != `IGNORED_ID) &&
                  (addr_byte[7:1] == own_low[7:1]);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hit       <= 1'b0;
      hit_pulse <= 1'b0;
      rw        <= 1'b0;
      hdr_ok    <= 1'b0;
    end else if (clear) begin
      hit       <= 1'b0;
      hit_pulse <= 1'b0;
      rw        <= 1'b0;
      hdr_ok    <= 1'b0;
    end else if (first && !ten_bit) begin
      hit       <= match7;
      hit_pulse <= match7;
      rw        <= addr_byte[0];
    end else if (first) begin
      hdr_ok    <= (addr_byte[7:3] == `TEN_HDR) &&
                   (addr_byte[2:1] == own_top);
      rw        <= addr_byte[0];
      hit_pulse <= 1'b0;
    end else if (second && ten_bit) begin
      hit       <= hdr_ok && (addr_byte == own_low);
      hit_pulse <= hdr_ok && (addr_byte == own_low);
    end else begin
      hit_pulse <= 1'b0;
    end
  end

endmodule : own_addr_match

// >>> verilog/i2c_cfg_data.sv
// Speed, data and own address registers of the two-wire interface.
// Assumes a serial engine on the same clock drives the event struct.
//
// Overview of operation
// - Rate register top bit picks standard (0) or fast (1); kept when off.
// - Seven-bit divider with the mode sets SCL rate; kept when off.
// - One 8-bit data register holds next byte out or last byte in.
// - Writing the data register while transmitting starts the byte at once.
// - First received byte lands automatically, chosen by the address direction bit.
// - Each further received byte waits for a software read of data.
// - Seven-bit mode: low address bits 7..1 form the answered address; kept.
// - Ten-bit mode: all eight low bits give the low address; kept.
// - Ten-bit mode: high register bits 2..1 give top address bits; kept.
// - Rate, data and low address registers reset to zero.
// - Interface off clears status but keeps configuration and address fields.
`timescale 1ns/100ps
`include "i2c_cfg_consts.svh"
module i2c_cfg_data
  import i2c_cfg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire reg_req_t   req,
  output logic [7:0]      rdata,
  input  wire bus_evt_t   evt,
  output logic            interface_on,
  output logic            ten_bit,
  output logic            bus_rate_select,
  output logic            tx_go,
  output logic [7:0]      tx_byte,
  output logic            rx_ready,
  output logic            addr_hit,
  output logic            slave_rw,
  output logic            scl_tick,
  output logic            hold_tick
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [7:0] bus_rate_reg;
  logic [7:0] bus_byte_reg;
  logic [7:0] own_id_low_reg;
  logic [7:0] own_id_high_reg;
  rx_state_t  rx_state;
  rx_state_t  next_rx_state;
  logic       hit_pulse;

  function automatic logic wr_at(input reg_req_t r, input logic [7:0] off);
    wr_at = r.wr && (r.addr == off);
  endfunction : wr_at

  function automatic logic rd_at(input reg_req_t r, input logic [7:0] off);
    rd_at = r.rd && (r.addr == off);
  endfunction : rd_at

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      interface_on <= 1'b0;
      ten_bit      <= 1'b0;
    end else if (wr_at(req, `OFF_CTL)) begin
      interface_on <= req.wdata[`CTL_ON_BIT];
      ten_bit      <= req.wdata[`CTL_TEN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Rate register
  // ----------------------------------------------------------------
  // No clear on interface off: rate survives a disable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rate_reg <= `RST_RATE;
    end else if (wr_at(req, `OFF_RATE)) begin
      bus_rate_reg <= req.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rate_select <= 1'b0;
    end else begin
      bus_rate_select <= bus_rate_reg[`RATE_SEL_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Own address registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      own_id_low_reg <= `RST_LOW;
    end else if (wr_at(req, `OFF_LOW)) begin
      own_id_low_reg <= req.wdata;
    end
  end

  // Band field locked while running so delays never change mid-frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      own_id_high_reg <= `RST_HIGH;
    end else if (wr_at(req, `OFF_HIGH)) begin
      if (interface_on) begin
        own_id_high_reg <= (own_id_high_reg & `HIGH_BAND_MASK) |
                           (req.wdata & `HIGH_ADDR_MASK);
      end else begin
        own_id_high_reg <= req.wdata & `HIGH_KEEP_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive pacing
  // ----------------------------------------------------------------
  always_comb begin
    next_rx_state = rx_state;
    case (rx_state)
      RX_IDLE: begin
        if (hit_pulse && !slave_rw) begin
          next_rx_state = RX_WAIT;
        end
      end
      RX_WAIT: begin
        if (evt.rx_valid) begin
          next_rx_state = RX_FULL;
        end
      end
      RX_FULL: begin
        if (rd_at(req, `OFF_BYTE)) begin
          next_rx_state = RX_WAIT;
        end
      end
      default: begin
        next_rx_state = RX_IDLE;
      end
    endcase
    // A new address restarts pacing, so a read direction never leaves it armed
    if (!interface_on || evt.stop || evt.addr_first) begin
      next_rx_state = RX_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state <= RX_IDLE;
      rx_ready <= 1'b0;
    end else begin
      rx_state <= next_rx_state;
      rx_ready <= (next_rx_state == RX_WAIT);
    end
  end

  // ----------------------------------------------------------------
  // Data register
  // ----------------------------------------------------------------
  // A captured byte beats a software write in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_byte_reg <= `RST_BYTE;
    end else if (interface_on && rx_ready && evt.rx_valid) begin
      bus_byte_reg <= evt.rx_data;
    end else if (wr_at(req, `OFF_BYTE)) begin
      bus_byte_reg <= req.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_go   <= 1'b0;
      tx_byte <= `RST_BYTE;
    end else begin
      tx_go <= wr_at(req, `OFF_BYTE) && interface_on && evt.transmitting;
      if (wr_at(req, `OFF_BYTE)) begin
        tx_byte <= req.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Address match and rate generation
  // ----------------------------------------------------------------
  own_addr_match u_match (
    .clk       (clk),
    .rst_n     (rst_n),
    .clear     (!interface_on || evt.stop),
    .ten_bit   (ten_bit),
    .own_low   (own_id_low_reg),
    .own_top   (own_id_high_reg[2:1]),
    .first     (evt.addr_first),
    .second    (evt.addr_second),
    .addr_byte (evt.addr_byte),
    .hit       (addr_hit),
    .hit_pulse (hit_pulse),
    .rw        (slave_rw)
  );

  scl_rate_gen u_rate (
    .clk       (clk),
    .rst_n     (rst_n),
    .run       (interface_on),
    .fast      (bus_rate_reg[`RATE_SEL_BIT]),
    .divider   (bus_rate_reg[6:0]),
    .band      (own_id_high_reg[7:6]),
    .scl_tick  (scl_tick),
    .hold_tick (hold_tick)
  );

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= `RST_ZERO;
    end else if (req.rd) begin
      case (req.addr)
        `OFF_CTL:  rdata <= {ten_bit, 1'b0, interface_on, 5'h00};
        `OFF_RATE: rdata <= bus_rate_reg;
        `OFF_LOW:  rdata <= own_id_low_reg;
        `OFF_HIGH: rdata <= own_id_high_reg & `HIGH_KEEP_MASK;
        `OFF_BYTE: rdata <= bus_byte_reg;
        `OFF_STAT: rdata <= {4'h0, slave_rw, addr_hit, rx_ready,
                             (rx_state == RX_FULL)};
        default:   rdata <= `RST_ZERO;
      endcase
    end else begin
      rdata <= `RST_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence byte_write_tx;
    req.wr && req.addr == `OFF_BYTE && interface_on && evt.transmitting;
  endsequence

  sequence byte_taken;
    interface_on && !evt.stop && rx_ready && evt.rx_valid;
  endsequence

  rate_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    req.wr && req.addr == `OFF_RATE
    |=> bus_rate_reg == $past(req.wdata)
    ##1 bus_rate_select == $past(bus_rate_reg[`RATE_SEL_BIT]))
    else $error("rate register write lost");

  keep_when_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(interface_on) |-> $stable(bus_rate_reg) && $stable(own_id_low_reg)
                            && $stable(own_id_high_reg[2:1]))
    else $error("configuration changed on disable");

  tx_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    byte_write_tx |=> tx_go && tx_byte == $past(req.wdata)
    ##1 (!tx_go || $past(req.wr && req.addr == `OFF_BYTE &&
                         interface_on && evt.transmitting)))
    else $error("byte write did not start transmission");

  rx_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    hit_pulse && !slave_rw && interface_on && !evt.stop && rx_state == RX_IDLE
    && !evt.addr_first |=> rx_ready)
    else $error("first byte not armed after address");

  rx_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
    byte_taken |=> bus_byte_reg == $past(evt.rx_data) && !rx_ready)
    else $error("received byte not captured");

  rx_release_a: assert property (@(posedge clk) disable iff (!rst_n)
    rx_state == RX_FULL && interface_on && !evt.stop && !evt.addr_first
    |-> if (req.rd && req.addr == `OFF_BYTE) ##1 rx_ready else ##1 !rx_ready)
    else $error("reception not paced by data reads");

  band_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
    interface_on && req.wr && req.addr == `OFF_HIGH
    |=> $stable(own_id_high_reg[7:6]))
    else $error("band changed while running");

  reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    req.rd && req.addr == `OFF_HIGH |=> rdata[5:3] == 3'h0 && rdata[0] == 1'b0)
    else $error("reserved bits not zero");

  off_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
    !interface_on |=> !rx_ready && !addr_hit && rx_state == RX_IDLE)
    else $error("status kept while disabled");

  ignored_id_a: assert property (@(posedge clk) disable iff (!rst_n)
    evt.addr_first && !ten_bit && own_id_low_reg == `IGNORED_ID |=> !hit_pulse)
    else $error("address 01h answered");

  dont_care_a: assert property (@(posedge clk) disable iff (!rst_n)
    interface_on && !evt.stop && evt.addr_first && !ten_bit
    && own_id_low_reg != `IGNORED_ID
    && evt.addr_byte[7:1] == own_id_low_reg[7:1]
    |=> addr_hit && slave_rw == $past(evt.addr_byte[0]))
    else $error("own address not matched");

  hold_follows_a: assert property (@(posedge clk) disable iff (!rst_n)
    interface_on && scl_tick && own_id_high_reg[7:6] == 2'b00
    && bus_rate_reg[6:0] > 7'h04
    |-> ##12 hold_tick)
    else $error("hold delay wrong for band 00");

endmodule : i2c_cfg_data

// >>> verif/bus_engine_model.sv
// Serial engine stand-in driving the event struct of the register block.
// Assumes calls are made just after a rising clock edge.
`timescale 1ns/100ps
module bus_engine_model
  import i2c_cfg_pkg::*;
(
  input  wire logic clk,
  output bus_evt_t  evt
);
  // ----------------------------------------------------------------
  // Event pulses
  // ----------------------------------------------------------------
  initial evt = '0;

  task automatic set_tx(input logic b);
    evt.transmitting <= b;
  endtask : set_tx

  // Released byte lines show the inverse, never a stale copy
  task automatic addr(input logic sec, input logic [7:0] b);
    if (evt.addr_first || evt.addr_second) @(posedge clk);
    evt.addr_first  <= ~sec;
    evt.addr_second <= sec;
    evt.addr_byte   <= b;
    @(posedge clk);
    evt.addr_first  <= 1'b0;
    evt.addr_second <= 1'b0;
    evt.addr_byte   <= ~b;
  endtask : addr

  // Pacing left to the caller so a refused byte can be offered
  task automatic rx(input logic [7:0] b);
    if (evt.rx_valid) @(posedge clk);
    evt.rx_valid <= 1'b1;
    evt.rx_data  <= b;
    @(posedge clk);
    evt.rx_valid <= 1'b0;
    evt.rx_data  <= ~b;
  endtask : rx

  task automatic stop();
    evt.stop <= 1'b1;
    @(posedge clk);
    evt.stop <= 1'b0;
  endtask : stop
endmodule : bus_engine_model

// >>> verif/i2c_cfg_data_bench.sv
// Self-checking bench for the speed, data and own address registers.
// Assumes the engine model on the same clock supplies bus events.
`timescale 1ns/100ps
`include "i2c_cfg_consts.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module i2c_cfg_data_bench;
  import i2c_cfg_pkg::*;
  logic       clk;
  logic       nrst;
  reg_req_t   req;
  bus_evt_t   evt;
  logic [7:0] rdata;
  logic [7:0] tx_byte;
  logic       tx_go;
  logic       rx_ready;
  logic       addr_hit;
  logic       slave_rw;
  logic       bus_rate_select;
  logic       scl_tick;
  logic       hold_tick;
  logic       interface_on;
  logic       ten_bit;
  int         mismatches;
  int         compares;
  int         n;

  i2c_cfg_data i2c_cfg_data_i (.clk(clk), .nrst(nrst), .req(req), .rdata(rdata), .evt(evt),
    .interface_on(interface_on), .ten_bit(ten_bit),
    .bus_rate_select(bus_rate_select), .tx_go(tx_go),
    .tx_byte(tx_byte), .rx_ready(rx_ready), .addr_hit(addr_hit), .slave_rw(slave_rw),
    .scl_tick(scl_tick), .hold_tick(hold_tick));
  bus_engine_model bus_engine_model_i (.clk(clk), .evt(evt));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Bus cycles and helpers
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (req.wr || req.rd) @(posedge clk);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge clk);
    req.wr    <= 1'b0;
  endtask : wr

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    if (req.wr || req.rd) @(posedge clk);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clk);
    req.rd   <= 1'b0;
    @(posedge clk);
    `CHK(nm, e, rdata)
  endtask : rdchk

  // Bounded wait: edges until the chosen tick is seen
  task automatic count_to(input bit hold, output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while ((hold ? hold_tick : scl_tick) !== 1'b1 && c < 200);
    if (c >= 200) begin
      mismatches++;
      summarize();
    end
  endtask : count_to

  task automatic hit_chk(input string nm, input logic sec, input logic [7:0] b,
                         input logic e);
    bus_engine_model_i.addr(sec, b);
    @(posedge clk);
    `CHK(nm, e, addr_hit)
  endtask : hit_chk

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdchk("rate rst", `OFF_RATE, 8'h00);
    rdchk("low rst", `OFF_LOW, 8'h00);
    rdchk("byte rst", `OFF_BYTE, 8'h00);
    rdchk("high rst", `OFF_HIGH, 8'h40);
    rdchk("unmapped", 8'h00, 8'h00);
  endtask : t_reset

  task automatic t_rate();
    wr(`OFF_RATE, 8'h89);
    wr(`OFF_CTL, 8'h20);
    @(posedge clk);
    `CHK("fast sel", 1'b1, bus_rate_select)
    count_to(0, n);
    count_to(0, n);
    `CHK("fast period", 20, n)
    count_to(0, n);
    count_to(1, n);
    `CHK("hold band 01", 10, n)
    wr(`OFF_RATE, 8'h09);
    count_to(0, n);
    count_to(0, n);
    count_to(0, n);
    `CHK("std period", 40, n)
    `CHK("std sel", 1'b0, bus_rate_select)
    wr(`OFF_CTL, 8'h00);
    rdchk("rate kept", `OFF_RATE, 8'h09);
    `CHK("off", 1'b0, interface_on)
    wr(`OFF_HIGH, 8'h00);
    wr(`OFF_CTL, 8'h20);
    count_to(0, n);
    count_to(1, n);
    `CHK("hold band 00", 12, n)
    wr(`OFF_HIGH, 8'hff);
    rdchk("band locked", `OFF_HIGH, 8'h06);
    wr(`OFF_CTL, 8'h00);
    wr(`OFF_HIGH, 8'hff);
    rdchk("high off", `OFF_HIGH, 8'hc6);
  endtask : t_rate

  task automatic t_tx();
    wr(`OFF_CTL, 8'h20);
    bus_engine_model_i.set_tx(1'b1);
    wr(`OFF_BYTE, 8'ha5);
    @(posedge clk);
    `CHK("tx go", 1'b1, tx_go)
    `CHK("tx byte", 8'ha5, tx_byte)
    @(posedge clk);
    `CHK("tx go once", 1'b0, tx_go)
    bus_engine_model_i.set_tx(1'b0);
    wr(`OFF_BYTE, 8'h5a);
    @(posedge clk);
    `CHK("no tx go", 1'b0, tx_go)
    `CHK("stored", 8'h5a, tx_byte)
  endtask : t_tx

  task automatic t_rx();
    wr(`OFF_LOW, 8'ha1);
    hit_chk("hit w", 1'b0, 8'ha0, 1'b1);
    `CHK("rw w", 1'b0, slave_rw)
    @(posedge clk);
    `CHK("first ready", 1'b1, rx_ready)
    bus_engine_model_i.rx(8'h3c);
    @(posedge clk);
    `CHK("paced", 1'b0, rx_ready)
    rdchk("stat full", `OFF_STAT, 8'h05);
    bus_engine_model_i.rx(8'h77);
    rdchk("first byte", `OFF_BYTE, 8'h3c);
    `CHK("ready again", 1'b1, rx_ready)
    bus_engine_model_i.rx(8'h77);
    rdchk("next byte", `OFF_BYTE, 8'h77);
    hit_chk("hit r", 1'b0, 8'ha1, 1'b1);
    `CHK("rw r", 1'b1, slave_rw)
    @(posedge clk);
    `CHK("no rx read", 1'b0, rx_ready)
    hit_chk("other addr", 1'b0, 8'hb2, 1'b0);
    wr(`OFF_LOW, 8'h01);
    hit_chk("id 01 a", 1'b0, 8'h00, 1'b0);
    hit_chk("id 01 b", 1'b0, 8'h01, 1'b0);
  endtask : t_rx

  task automatic t_ten();
    wr(`OFF_CTL, 8'ha0);
    wr(`OFF_HIGH, 8'h06);
    wr(`OFF_LOW, 8'h5c);
    `CHK("ten mode", 1'b1, ten_bit)
    bus_engine_model_i.addr(1'b0, 8'hf6);
    hit_chk("ten hit", 1'b1, 8'h5c, 1'b1);
    bus_engine_model_i.stop();
    @(posedge clk);
    `CHK("stop clears", 1'b0, addr_hit)
    bus_engine_model_i.addr(1'b0, 8'hf2);
    hit_chk("ten top", 1'b1, 8'h5c, 1'b0);
    bus_engine_model_i.addr(1'b0, 8'hf6);
    hit_chk("ten low", 1'b1, 8'h5d, 1'b0);
  endtask : t_ten

  initial begin
    req        = '0;
    nrst       = 1'b0;
    mismatches = 0;
    compares   = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_rate();
    t_tx();
    t_rx();
    t_ten();
    summarize();
  end
endmodule : i2c_cfg_data_bench
